/* design/rfe_pkg.sv */
// Constants and types for the receive frame emitter.
// Assumes a byte-wide host stream and a plain register port.
package rfe_pkg;

	// Frame framing bytes and frame type codes.
	localparam logic [7:0]  SOF         = 8'h7e;
	localparam logic [7:0]  TYPE_RX     = 8'h90;
	localparam logic [7:0]  TYPE_EXP    = 8'h91;
	localparam logic [7:0]  TYPE_AGG    = 8'h8e;
	localparam logic [7:0]  RSVD_HI     = 8'hff;
	localparam logic [7:0]  RSVD_LO     = 8'hfe;
	localparam logic [7:0]  AGG_RSVD    = 8'h00;
	localparam logic [7:0]  CK_BASE     = 8'hff;
	// Receive option bits kept: acked, broadcast and delivery method.
	localparam logic [7:0]  RXOPT_KEEP  = 8'hc3;

	// Byte offsets inside a frame.
	localparam logic [15:0] OFF_LEN_HI  = 16'h0001;
	localparam logic [15:0] OFF_LEN_LO  = 16'h0002;
	localparam logic [15:0] OFF_TYPE    = 16'h0003;
	localparam logic [15:0] OFF_ADDR    = 16'h0004;
	localparam logic [15:0] OFF_ADDR_E  = 16'h000b;
	localparam logic [15:0] OFF_RSVD    = 16'h000c;
	localparam logic [15:0] OFF_RSVD2   = 16'h000d;
	localparam logic [15:0] OFF_OPT     = 16'h000e;
	localparam logic [15:0] OFF_SEP     = 16'h000e;
	localparam logic [15:0] OFF_DEP     = 16'h000f;
	localparam logic [15:0] OFF_CLU     = 16'h0010;
	localparam logic [15:0] OFF_PRO     = 16'h0012;
	localparam logic [15:0] OFF_XOPT    = 16'h0014;
	localparam logic [15:0] OFF_AGG_RS  = 16'h0004;
	localparam logic [15:0] OFF_AGG_NEW = 16'h0005;
	localparam logic [15:0] OFF_AGG_OLD = 16'h000d;
	localparam logic [15:0] HDR_STD     = 16'h000f;
	localparam logic [15:0] HDR_EXP     = 16'h0015;
	localparam logic [15:0] HDR_AGG     = 16'h0015;
	localparam logic [2:0]  AGG_ADDR_J  = 3'h5;

	// Register byte addresses and fields.
	localparam logic [7:0]  REG_OPT     = 8'h00;
	localparam logic [7:0]  REG_DSTH    = 8'h04;
	localparam logic [7:0]  REG_DSTL    = 8'h08;
	localparam logic [7:0]  REG_STAT    = 8'h0c;
	localparam int          OPT_EXP_BIT = 1;
	localparam logic [7:0]  OPT_RST     = 8'h00;
	localparam logic [63:0] DST_RST     = 64'h0000_0000_0000_0000;

	// Kind of frame being emitted.
	typedef enum logic [1:0] {KIND_STD, KIND_EXP, KIND_AGG} rfe_kind_t;

endpackage

/* design/rfe_fifo.sv */
// Small payload FIFO with valid/ready on both sides.
// Assumes a single clock; the read side may stall to build back-pressure.
module rfe_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,       // Clock.
	input  wire logic             arst_n,    // Asynchronous reset, low.
	input  wire logic             in_valid,  // Write side has data.
	output logic                  in_ready_q, // Room for a word.
	input  wire logic [WIDTH-1:0] in_data,   // Write data.
	output logic                  out_valid, // Read side has data.
	input  wire logic             out_ready, // Read side takes data.
	output logic      [WIDTH-1:0] out_data   // Read data.
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	////////////////////////////////////////////////////////////////////////
	// Handshakes on both sides.
	assign push      = in_valid && in_ready_q;
	assign pop       = out_valid && out_ready;
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];

	// Storage is written only on an accepted word.
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers wrap at the depth; count gives honest full and empty.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wr_q       <= '0;
			rd_q       <= '0;
			cnt_q      <= '0;
			in_ready_q <= 1'b0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q      <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
			in_ready_q <= (cnt_q + (AW+1)'(push) - (AW+1)'(pop))
				!= (AW+1)'(DEPTH);
		end
	end
endmodule

/* design/rfe_cksum.sv */
// Running checksum over the bytes of one frame.
// Assumes the caller clears it at the start of each frame.
module rfe_cksum (
	input  wire logic       clk,    // Clock.
	input  wire logic       arst_n, // Asynchronous reset, low.
	input  wire logic       clr,    // Start a new sum.
	input  wire logic       add,    // Add the byte below.
	input  wire logic [7:0] din,    // Byte to add.
	output logic      [7:0] sum_q,  // Low eight bits of the sum.
	output logic      [7:0] ck      // Checksum byte to send.
);
	// Sum wraps naturally at eight bits.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sum_q <= 8'h00;
		end else if (clr) begin
			sum_q <= 8'h00;
		end else if (add) begin
			sum_q <= sum_q + din;
		end
	end

	// Checksum is the base value less the sum.
	assign ck = rfe_pkg::CK_BASE - sum_q;
endmodule

/* design/rfe_emitter.sv */
// Receive frame emitter: builds 0x90, 0x91 and 0x8e host frames.
// Assumes metadata arrives with a payload byte count, payload follows
// on the payload stream, and the host drains bytes with out_ready.
module rfe_emitter #(
	parameter int FIFO_DEPTH = 4
) (
	input  wire logic        clk,        // Clock, 100 MHz.
	input  wire logic        arst_n,     // Asynchronous reset, low.
	input  wire logic [7:0]  reg_addr,   // Register byte address.
	input  wire logic [31:0] reg_wdata,  // Register write data.
	input  wire logic        reg_wr,     // Write strobe.
	input  wire logic        reg_rd,     // Read strobe.
	output logic      [31:0] reg_rdata_q, // Read data, cycle after.
	input  wire logic        hdr_valid,  // Packet metadata offered.
	output logic             hdr_ack_q,  // Metadata taken, pulse.
	input  wire logic [63:0] hdr_src,    // Sender address.
	input  wire logic [7:0]  hdr_opts,   // Receive option flags.
	input  wire logic [7:0]  hdr_sep,    // Source endpoint.
	input  wire logic [7:0]  hdr_dep,    // Destination endpoint.
	input  wire logic [15:0] hdr_cluster, // Cluster identifier.
	input  wire logic [15:0] hdr_profile, // Profile identifier.
	input  wire logic [15:0] hdr_plen,   // Payload byte count.
	input  wire logic        pay_valid,  // Payload byte offered.
	output logic             pay_ready_q, // Payload FIFO has room.
	input  wire logic [7:0]  pay_data,   // Payload byte.
	input  wire logic        upd_valid,  // Aggregator update offered.
	output logic             upd_ack_q,  // Update taken, pulse.
	input  wire logic [63:0] upd_match,  // Address the update targets.
	input  wire logic [63:0] upd_new,    // Replacement destination.
	output logic      [7:0]  out_data_q, // Frame byte to host.
	output logic             out_valid_q, // Frame byte valid.
	input  wire logic        out_ready   // Host takes the byte.
);
	typedef enum logic {ST_IDLE, ST_SEND} rfe_state_t;

	rfe_state_t              state_q;
	rfe_pkg::rfe_kind_t      kind_q;
	logic [7:0]              api_output_options_q;
	logic [63:0]             dst_q;
	logic [63:0]             old_q;
	logic [63:0]             src_q;
	logic [7:0]              opts_q;
	logic [7:0]              sep_q;
	logic [7:0]              dep_q;
	logic [15:0]             clu_q;
	logic [15:0]             pro_q;
	logic [15:0]             len_q;
	logic [15:0]             hdr_len_q;
	logic [15:0]             last_q;
	logic [15:0]             idx_q;
	logic [15:0]             emit_off_q;
	logic [15:0]             frames_q;
	logic                    fifo_valid;
	logic [7:0]              fifo_data;
	logic                    in_pay;
	logic                    avail;
	logic                    ld;
	logic                    take_upd;
	logic                    take_hdr;
	logic                    upd_hit;
	logic [7:0]              hbyte;
	logic [7:0]              next_byte;
	logic [7:0]              ck_sum;
	logic [7:0]              ck_byte;

	////////////////////////////////////////////////////////////////////////
	// Payload buffer; its room flag is the payload source's ready.
	rfe_fifo #(
		.WIDTH (8),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk        (clk),
		.arst_n     (arst_n),
		.in_valid   (pay_valid),
		.in_ready_q (pay_ready_q),
		.in_data    (pay_data),
		.out_valid  (fifo_valid),
		.out_ready  (ld && in_pay),
		.out_data   (fifo_data)
	);

	// Checksum covers every byte from the type byte through the payload.
	rfe_cksum u_ck (
		.clk    (clk),
		.arst_n (arst_n),
		.clr    ((take_upd && upd_hit) || take_hdr),
		.add    (ld && idx_q >= rfe_pkg::OFF_TYPE && idx_q != last_q),
		.din    (next_byte),
		.sum_q  (ck_sum),
		.ck     (ck_byte)
	);

	////////////////////////////////////////////////////////////////////////
	// Byte j (0 is most significant) of a 64-bit address.
	function automatic logic [7:0] addr_byte(input logic [63:0] a,
			input logic [2:0] j);
		logic [63:0] t;
		t = a << {j, 3'b000};
		return t[63:56];
	endfunction

	// Acceptance: updates win over packets, both only while idle, and never
	// again in the cycle where the acknowledge of the same request stands.
	assign upd_hit  = (upd_match == dst_q);
	assign take_upd = (state_q == ST_IDLE) && upd_valid && !upd_ack_q;
	assign take_hdr = (state_q == ST_IDLE) && !upd_valid && hdr_valid
		&& !hdr_ack_q;

	// Header byte by frame offset and kind.
	always_comb begin
		hbyte = 8'h00;
		if (idx_q == 16'h0000) begin
			hbyte = rfe_pkg::SOF;
		end else if (idx_q == rfe_pkg::OFF_LEN_HI) begin
			hbyte = len_q[15:8];
		end else if (idx_q == rfe_pkg::OFF_LEN_LO) begin
			hbyte = len_q[7:0];
		end else if (kind_q == rfe_pkg::KIND_AGG) begin
			if (idx_q == rfe_pkg::OFF_TYPE) begin
				hbyte = rfe_pkg::TYPE_AGG;
			end else if (idx_q == rfe_pkg::OFF_AGG_RS) begin
				hbyte = rfe_pkg::AGG_RSVD;
			end else if (idx_q < rfe_pkg::OFF_AGG_OLD) begin
				hbyte = addr_byte(dst_q, idx_q[2:0] - rfe_pkg::AGG_ADDR_J);
			end else begin
				hbyte = addr_byte(old_q, idx_q[2:0] - rfe_pkg::AGG_ADDR_J);
			end
		end else if (idx_q == rfe_pkg::OFF_TYPE) begin
			hbyte = (kind_q == rfe_pkg::KIND_EXP) ? rfe_pkg::TYPE_EXP
				: rfe_pkg::TYPE_RX;
		end else if (idx_q <= rfe_pkg::OFF_ADDR_E) begin
			hbyte = addr_byte(src_q, {~idx_q[2], idx_q[1:0]});
		end else if (idx_q == rfe_pkg::OFF_RSVD) begin
			hbyte = rfe_pkg::RSVD_HI;
		end else if (idx_q == rfe_pkg::OFF_RSVD2) begin
			hbyte = rfe_pkg::RSVD_LO;
		end else if (kind_q == rfe_pkg::KIND_STD) begin
			hbyte = opts_q;
		end else begin
			unique case (idx_q)
				rfe_pkg::OFF_SEP:        hbyte = sep_q;
				rfe_pkg::OFF_DEP:        hbyte = dep_q;
				rfe_pkg::OFF_CLU:        hbyte = clu_q[15:8];
				rfe_pkg::OFF_CLU + 16'h1: hbyte = clu_q[7:0];
				rfe_pkg::OFF_PRO:        hbyte = pro_q[15:8];
				rfe_pkg::OFF_PRO + 16'h1: hbyte = pro_q[7:0];
				default:                 hbyte = opts_q;
			endcase
		end
	end

	// Pick header, payload or checksum and decide whether to load.
	assign in_pay    = (idx_q >= hdr_len_q) && (idx_q != last_q);
	assign avail     = !in_pay || fifo_valid;
	assign next_byte = (idx_q == last_q) ? ck_byte
		: (in_pay ? fifo_data : hbyte);
	assign ld        = (state_q == ST_SEND) && avail
		&& (!out_valid_q || out_ready);

	////////////////////////////////////////////////////////////////////////
	// Frame sequencer: offsets walk upward to the checksum.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q  <= ST_IDLE;
			idx_q    <= 16'h0000;
			frames_q <= 16'h0000;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
					idx_q <= 16'h0000;
					if ((take_upd && upd_hit) || take_hdr) begin
						state_q <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (ld) begin
						idx_q <= idx_q + 16'h0001;
						if (idx_q == last_q) begin
							state_q  <= ST_IDLE;
							frames_q <= frames_q + 16'h0001;
						end
					end
				end
			endcase
		end
	end

	// Metadata latch; receive option reserved bits read as zero.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			kind_q    <= rfe_pkg::KIND_STD;
			src_q     <= 64'h0;
			opts_q    <= 8'h00;
			sep_q     <= 8'h00;
			dep_q     <= 8'h00;
			clu_q     <= 16'h0000;
			pro_q     <= 16'h0000;
			len_q     <= 16'h0000;
			hdr_len_q <= 16'h0000;
			last_q    <= 16'h0000;
		end else if (take_upd && upd_hit) begin
			kind_q    <= rfe_pkg::KIND_AGG;
			len_q     <= rfe_pkg::HDR_AGG - rfe_pkg::OFF_TYPE;
			hdr_len_q <= rfe_pkg::HDR_AGG;
			last_q    <= rfe_pkg::HDR_AGG;
		end else if (take_hdr) begin
			src_q  <= hdr_src;
			opts_q <= hdr_opts & rfe_pkg::RXOPT_KEEP;
			sep_q  <= hdr_sep;
			dep_q  <= hdr_dep;
			clu_q  <= hdr_cluster;
			pro_q  <= hdr_profile;
			if (api_output_options_q[rfe_pkg::OPT_EXP_BIT]) begin
				kind_q    <= rfe_pkg::KIND_EXP;
				len_q     <= rfe_pkg::HDR_EXP - rfe_pkg::OFF_TYPE + hdr_plen;
				hdr_len_q <= rfe_pkg::HDR_EXP;
				last_q    <= rfe_pkg::HDR_EXP + hdr_plen;
			end else begin
				kind_q    <= rfe_pkg::KIND_STD;
				len_q     <= rfe_pkg::HDR_STD - rfe_pkg::OFF_TYPE + hdr_plen;
				hdr_len_q <= rfe_pkg::HDR_STD;
				last_q    <= rfe_pkg::HDR_STD + hdr_plen;
			end
		end
	end

	// Output byte register holds until the host takes it.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			out_data_q  <= 8'h00;
			out_valid_q <= 1'b0;
			emit_off_q  <= 16'h0000;
		end else if (ld) begin
			out_data_q  <= next_byte;
			out_valid_q <= 1'b1;
			emit_off_q  <= idx_q;
		end else if (out_ready) begin
			out_valid_q <= 1'b0;
		end
	end

	// Acceptance pulses toward the receive path.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hdr_ack_q <= 1'b0;
			upd_ack_q <= 1'b0;
		end else begin
			hdr_ack_q <= take_hdr;
			upd_ack_q <= take_upd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Settings: an update that hits wins over a bus write to the address.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			api_output_options_q <= rfe_pkg::OPT_RST;
			dst_q                <= rfe_pkg::DST_RST;
			old_q                <= rfe_pkg::DST_RST;
		end else begin
			if (reg_wr && reg_addr == rfe_pkg::REG_OPT) begin
				api_output_options_q <= reg_wdata[7:0];
			end
			if (take_upd && upd_hit) begin
				old_q <= dst_q;
				dst_q <= upd_new;
			end else if (reg_wr && reg_addr == rfe_pkg::REG_DSTH) begin
				dst_q[63:32] <= reg_wdata;
			end else if (reg_wr && reg_addr == rfe_pkg::REG_DSTL) begin
				dst_q[31:0] <= reg_wdata;
			end
		end
	end

	// Read data stand one cycle after the strobe; unmapped reads zero.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata_q <= 32'h0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				rfe_pkg::REG_OPT:  reg_rdata_q <= {24'h0,
					api_output_options_q};
				rfe_pkg::REG_DSTH: reg_rdata_q <= dst_q[63:32];
				rfe_pkg::REG_DSTL: reg_rdata_q <= dst_q[31:0];
				rfe_pkg::REG_STAT: reg_rdata_q <= {frames_q, 15'h0,
					(state_q == ST_SEND)};
				default:           reg_rdata_q <= 32'h0;
			endcase
		end else begin
			reg_rdata_q <= 32'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks on the emitted byte stream and on update acceptance.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	wire shown = out_valid_q;

	property p_sof;
		ld && idx_q == 16'h0000 |=> out_data_q == rfe_pkg::SOF;
	endproperty
	a_sof: assert property (p_sof) else $error("bad start byte");

	property p_len;
		shown && emit_off_q == rfe_pkg::OFF_LEN_LO
			|-> {$past(out_data_q, 1) , out_data_q} == len_q
			|| !$past(ld);
	endproperty
	a_len: assert property (p_len) else $error("bad length");

	property p_ck;
		shown && emit_off_q == last_q && state_q == ST_IDLE
			|-> 8'(out_data_q + ck_sum) == rfe_pkg::CK_BASE;
	endproperty
	a_ck: assert property (p_ck) else $error("bad checksum");

	property p_type;
		ld && idx_q == rfe_pkg::OFF_TYPE && kind_q != rfe_pkg::KIND_AGG
			|=> out_data_q == (kind_q == rfe_pkg::KIND_EXP
			? rfe_pkg::TYPE_EXP : rfe_pkg::TYPE_RX);
	endproperty
	a_type: assert property (p_type) else $error("bad type");

	property p_rsvd;
		ld && idx_q == rfe_pkg::OFF_RSVD && kind_q != rfe_pkg::KIND_AGG
			|=> out_data_q == rfe_pkg::RSVD_HI;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("bad reserved");

	property p_opt;
		ld && idx_q == rfe_pkg::OFF_OPT && kind_q == rfe_pkg::KIND_STD
			|=> out_data_q[5:2] == 4'h0;
	endproperty
	a_opt: assert property (p_opt) else $error("reserved opt set");

	property p_agg0;
		ld && idx_q == rfe_pkg::OFF_AGG_RS && kind_q == rfe_pkg::KIND_AGG
			|=> out_data_q == rfe_pkg::AGG_RSVD;
	endproperty
	a_agg0: assert property (p_agg0) else $error("agg byte 4");

	property p_upd;
		take_upd && upd_hit |=> dst_q == $past(upd_new)
			&& state_q == ST_SEND;
	endproperty
	a_upd: assert property (p_upd) else $error("update lost");

	property p_hold;
		shown && !out_ready |=> shown && $stable(out_data_q);
	endproperty
	a_hold: assert property (p_hold) else $error("byte dropped");

	c_std: cover property (take_hdr && !api_output_options_q[1]);
	c_exp: cover property (take_hdr && api_output_options_q[1]);
	c_agg: cover property (take_upd && upd_hit);
	c_full: cover property (!pay_ready_q && state_q == ST_SEND);
endmodule

/* sim/rfe_host.sv */
// Host model: drains frame bytes from the emitter and checks framing.
// Assumes one clock shared with the emitter and frames sent back to back.
module rfe_host (
	input  wire logic       clk,      // Clock.
	input  wire logic       arst_n,   // Asynchronous reset, low.
	input  wire logic [7:0] data,     // Frame byte from the emitter.
	input  wire logic       valid,    // Frame byte offered.
	input  wire logic       slow,     // Stall every other cycle when high.
	output logic            ready,    // Host takes the byte.
	output logic            got,      // One byte taken, pulse.
	output logic      [7:0] got_byte, // Byte taken.
	output int              ck_errs   // Frames with bad start or checksum.
);
	timeunit 1ns;
	timeprecision 1ps;
	int         idx;
	int         len;
	logic [7:0] sum;

	////////////////////////////////////////////////////////////////////////
	// Take bytes in offset order and track length and running sum.
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ready   <= 1'b0;
			got     <= 1'b0;
			idx     <= 0;
			len     <= 0;
			sum     <= 8'h00;
			ck_errs <= 0;
		end else begin
			ready    <= slow ? ~ready : 1'b1;
			got      <= valid && ready;
			got_byte <= data;
			if (valid && ready) begin
				idx <= idx + 1;
				if (idx == 0) begin
					if (data !== 8'h7e) ck_errs <= ck_errs + 1;
				end else if (idx == 1) begin
					len <= int'(data) << 8;
				end else if (idx == 2) begin
					len <= len + int'(data);
				end else if (idx == len + 3) begin
					if (8'(sum + data) !== 8'hff) ck_errs <= ck_errs + 1;
					idx <= 0;
					sum <= 8'h00;
				end else begin
					sum <= sum + data;
				end
			end
		end
	end
endmodule

/* sim/testbench.sv */
// Self-checking bench for the receive frame emitter.
// Assumes rfe_pkg, rfe_fifo, rfe_cksum, rfe_emitter and rfe_host.
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, arst_n, reg_wr, reg_rd, hdr_valid, hdr_ack_q;
	logic        pay_valid, pay_ready_q, upd_valid, upd_ack_q;
	logic        out_valid_q, out_ready, slow, got;
	logic [7:0]  reg_addr, hdr_opts, hdr_sep, hdr_dep, pay_data;
	logic [7:0]  out_data_q, got_byte;
	logic [31:0] reg_wdata, reg_rdata_q, seed;
	logic [63:0] hdr_src, upd_match, upd_new, dst;
	logic [15:0] hdr_cluster, hdr_profile, hdr_plen;
	logic [7:0]  body[$], exp[$], rx[$];
	int          ck_errs, err_total, check_count, opt_set, frame_total, i, n;

	rfe_emitter #(.FIFO_DEPTH(4)) rfe_emitter_i (.clk(clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .hdr_valid(hdr_valid),
		.hdr_ack_q(hdr_ack_q), .hdr_src(hdr_src), .hdr_opts(hdr_opts),
		.hdr_sep(hdr_sep), .hdr_dep(hdr_dep), .hdr_cluster(hdr_cluster),
		.hdr_profile(hdr_profile), .hdr_plen(hdr_plen),
		.pay_valid(pay_valid), .pay_ready_q(pay_ready_q),
		.pay_data(pay_data), .upd_valid(upd_valid), .upd_ack_q(upd_ack_q),
		.upd_match(upd_match), .upd_new(upd_new), .out_data_q(out_data_q),
		.out_valid_q(out_valid_q), .out_ready(out_ready));
	rfe_host rfe_host_i (.clk(clk), .arst_n(arst_n), .data(out_data_q),
		.valid(out_valid_q), .slow(slow), .ready(out_ready), .got(got),
		.got_byte(got_byte), .ck_errs(ck_errs));

	////////////////////////////////////////////////////////////////////////
	// Clock, byte capture and watchdog.
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (got) rx.push_back(got_byte);
	initial begin
		repeat (50000) @(posedge clk);
		bad("watchdog expired");
		end_sim();
	end

	////////////////////////////////////////////////////////////////////////
	// Helpers: random source, reporting and handshakes.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic bad(input string m);
		err_total++;
		$display("wrong value at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e,
			input string m);
		check_count++;
		if (g !== e) bad(m);
	endtask
	// Hold the request until the edge where the answer is sampled high.
	task automatic wait_hi(ref logic s);
		int k;
		k = 0;
		@(negedge clk);
		while (s !== 1'b1 && k < 300) begin
			@(negedge clk);
			k++;
		end
		if (k >= 300) bad("handshake timed out");
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk(reg_rdata_q, e, "register read");
		@(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Reference frame builder and comparison with what the host took.
	task automatic put16(input logic [15:0] v);
		body.push_back(v[15:8]);
		body.push_back(v[7:0]);
	endtask
	task automatic put64(input logic [63:0] v);
		for (int j = 7; j >= 0; j--) body.push_back(v[8*j+:8]);
	endtask
	task automatic seal();
		logic [7:0] ck;
		ck = 8'hff;
		exp.push_back(8'h7e);
		exp.push_back(8'(body.size() >> 8));
		exp.push_back(8'(body.size()));
		foreach (body[j]) ck = ck - body[j];
		foreach (body[j]) exp.push_back(body[j]);
		exp.push_back(ck);
		body = {};
		frame_total++;
	endtask
	task automatic drain(input string name);
		int k;
		k = 0;
		while (rx.size() < exp.size() && k < 3000) begin
			@(posedge clk);
			k++;
		end
		@(negedge clk);
		chk(rx.size(), exp.size(), "frame length seen by host");
		foreach (exp[j]) if (j < rx.size()) chk(rx[j], exp[j], "frame byte");
		rx  = {};
		exp = {};
		$display("test %s done", name);
		@(posedge clk);
	endtask

	// One received packet with delivery method m and n payload bytes.
	task automatic pkt(input logic [1:0] m, input int n);
		logic [7:0]  pd[$];
		logic [31:0] r;
		logic [63:0] src;
		r   = rnd();
		src = {r, rnd()};
		r   = rnd();
		hdr_src     <= src;
		hdr_opts    <= {m, r[5:0]};
		hdr_sep     <= r[15:8];
		hdr_dep     <= r[23:16];
		hdr_cluster <= r[31:16];
		hdr_profile <= r[15:0];
		hdr_plen    <= 16'(n);
		body.push_back(opt_set[1] ? 8'h91 : 8'h90);
		put64(src);
		put16(16'hfffe);
		if (opt_set[1]) begin
			body.push_back(r[15:8]);
			body.push_back(r[23:16]);
			put16(r[31:16]);
			put16(r[15:0]);
		end
		body.push_back({m, 4'h0, r[1:0]});
		for (int j = 0; j < n; j++) begin
			r = rnd();
			pd.push_back(r[7:0]);
			body.push_back(r[7:0]);
		end
		seal();
		fork
			begin
				hdr_valid <= 1'b1;
				wait_hi(hdr_ack_q);
				hdr_valid <= 1'b0;
			end
			begin
				foreach (pd[j]) begin
					pay_valid <= 1'b1;
					pay_data  <= pd[j];
					wait_hi(pay_ready_q);
				end
				pay_valid <= 1'b0;
			end
		join
		drain("packet");
	endtask

	// Aggregator update; a frame follows only when the target matches.
	task automatic upd(input logic [63:0] t, input logic [63:0] nw);
		if (t === dst) begin
			body.push_back(8'h8e);
			body.push_back(8'h00);
			put64(nw);
			put64(dst);
			seal();
			dst = nw;
		end
		upd_match <= t;
		upd_new   <= nw;
		upd_valid <= 1'b1;
		wait_hi(upd_ack_q);
		upd_valid <= 1'b0;
		drain("update");
		rd(8'h04, dst[63:32]);
		rd(8'h08, dst[31:0]);
	endtask

	task automatic end_sim();
		check_count++;
		if (ck_errs !== 0) bad("host saw a bad frame");
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial begin
		{reg_wr, reg_rd, hdr_valid, pay_valid, upd_valid, slow} = 6'h00;
		{reg_addr, reg_wdata, hdr_opts, hdr_sep, hdr_dep, pay_data} = 0;
		{hdr_src, hdr_cluster, hdr_profile, hdr_plen} = 0;
		{upd_match, upd_new, dst} = 0;
		{err_total, check_count, opt_set, frame_total} = 0;
		seed   = 32'h0000_0019;
		arst_n = 1'b0;
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		@(posedge clk);
		rd(8'h00, 32'h0000_0000);
		rd(8'h04, 32'h0000_0000);
		rd(8'h08, 32'h0000_0000);
		rd(8'h0c, 32'h0000_0000);
		rd(8'h10, 32'h0000_0000);
		$display("test reset done");
		// Both frame kinds, all delivery methods, lengths around the FIFO.
		for (opt_set = 0; opt_set < 3; opt_set += 2) begin
			wr(8'h00, 32'(opt_set));
			rd(8'h00, 32'(opt_set));
			for (i = 0; i < 4; i++) pkt(2'(i), i * 3);
		end
		// The register still holds the explicit setting from the last pass.
		opt_set = 2;
		// Host stalls while a long payload backs up the FIFO.
		slow <= 1'b1;
		pkt(2'h3, 23);
		slow <= 1'b0;
		wr(8'h04, 32'h0a1b_2c3d);
		wr(8'h08, 32'h4e5f_6071);
		dst = 64'h0a1b_2c3d_4e5f_6071;
		upd(64'h0a1b_2c3d_4e5f_6070, 64'h1111_2222_3333_4444);
		upd(dst, 64'h8877_6655_4433_2211);
		opt_set = 0;
		wr(8'h00, 32'(opt_set));
		pkt(2'h1, 2);
		// Status counts every frame sent, and the sequencer is idle.
		rd(8'h0c, 32'(frame_total) << 16);
		end_sim();
	end
endmodule
